// ===== core/pcg_source.sv
// Clock source end: divides the main clock into the peripheral clock and enable.
`include "pcg_regs.svh"

module pcg_source #(
    parameter int RATIO     = `PCG_RATIO_DEFAULT,
    parameter int RED_DELAY = `PCG_RED_DELAY_DEFAULT,
    parameter bit LOCK_STEP = 1'b1
) (
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    input  wire logic i_clock_stop,
    pcg_link_if.src   link,
    output logic      o_main_clock
);
    import pcg_pkg::*;

    // ------------------------------------------------------------
    // Ratio counter
    // ------------------------------------------------------------
    localparam int EFF_RATIO = (RATIO < `PCG_RATIO_MIN) ? `PCG_RATIO_MIN : RATIO;
    localparam pcg_cnt_t LAST = pcg_cnt_t'(EFF_RATIO - 1);
    localparam pcg_cnt_t HALF = pcg_cnt_t'(EFF_RATIO / 2);

    // ------------------------------------------------------------
    // Counter arithmetic
    // ------------------------------------------------------------
    // A ratio below the minimum is raised to it quietly, because the block
    // has no way to report a bad build setting to anyone.
    function automatic pcg_cnt_t cnt_inc(input pcg_cnt_t value);
        return value + pcg_cnt_t'(1);
    endfunction

    function automatic logic cnt_is_last(input pcg_cnt_t value);
        return value == LAST;
    endfunction

    // The clock falls once the count has covered half a period.
    function automatic logic cnt_at_fall(input pcg_cnt_t value);
        return cnt_inc(value) == HALF;
    endfunction

    pcg_state_e state;
    pcg_state_e next_state;
    pcg_cnt_t   count;
    pcg_cnt_t   next_count;
    logic       pclk;
    logic       next_pclk;
    logic       pen;
    logic       next_pen;

    assign o_main_clock = i_sys_clk;

    always_comb begin
        next_state = state;
        next_count = count;
        next_pclk  = pclk;
        next_pen   = 1'b0;
        unique case (state)
            PCG_IDLE: begin
                // Start one cycle after reset release so the first period is full.
                if (!i_clock_stop) begin
                    next_state = PCG_RUN;
                    next_count = LAST;
                end
            end
            PCG_RUN: begin
                if (i_clock_stop) begin
                    next_state = PCG_IDLE;
                    next_pclk  = 1'b0;
                end else if (cnt_is_last(count)) begin
                    next_count = '0;
                    next_pclk  = 1'b1;
                    next_pen   = 1'b1;
                end else begin
                    // A stop in mid-period drops the clock at once; a short high
                    // phase is the price of halting without delay.
                    next_count = cnt_inc(count);
                    if (cnt_at_fall(count)) begin
                        next_pclk = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= PCG_IDLE;
            count <= '0;
            pclk  <= 1'b0;
            pen   <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            pclk  <= next_pclk;
            pen   <= next_pen;
        end
    end

    assign link.peripheral_clock        = pclk;
    assign link.peripheral_clock_enable = pen;

    // ------------------------------------------------------------
    // Redundant copies
    // ------------------------------------------------------------
    // Stop is held high during reset, then follows the primary stop late.
    // One shift line per signal keeps the three copies in step for any delay.
    function automatic logic [RED_DELAY-1:0] shift_in(
        input logic [RED_DELAY-1:0] line,
        input logic                 bit_in
    );
        logic [RED_DELAY-1:0] result;
        result    = line << 1;
        result[0] = bit_in;
        return result;
    endfunction

    logic [RED_DELAY-1:0] dly_clk;
    logic [RED_DELAY-1:0] next_dly_clk;
    logic [RED_DELAY-1:0] dly_en;
    logic [RED_DELAY-1:0] next_dly_en;
    logic [RED_DELAY-1:0] dly_stop;
    logic [RED_DELAY-1:0] next_dly_stop;

    // ------------------------------------------------------------
    // Redundant clock delay
    // ------------------------------------------------------------
    always_comb begin
        next_dly_clk = shift_in(dly_clk, pclk);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dly_clk <= '0;
        end else begin
            dly_clk <= next_dly_clk;
        end
    end

    // ------------------------------------------------------------
    // Redundant enable delay
    // ------------------------------------------------------------
    always_comb begin
        next_dly_en = shift_in(dly_en, pen);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dly_en <= '0;
        end else begin
            dly_en <= next_dly_en;
        end
    end

    // ------------------------------------------------------------
    // Redundant stop delay
    // ------------------------------------------------------------
    always_comb begin
        next_dly_stop = shift_in(dly_stop, i_clock_stop);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dly_stop <= '1;
        end else begin
            dly_stop <= next_dly_stop;
        end
    end

    // ------------------------------------------------------------
    // Lock-step select
    // ------------------------------------------------------------
    // Without lock-step the redundant outputs are held inactive, stop high.
    logic red_clk_out;
    logic red_en_out;
    logic red_stop_out;

    always_comb begin
        if (LOCK_STEP) begin
            red_clk_out  = dly_clk[RED_DELAY-1];
            red_en_out   = dly_en[RED_DELAY-1];
            red_stop_out = dly_stop[RED_DELAY-1];
        end else begin
            red_clk_out  = 1'b0;
            red_en_out   = 1'b0;
            red_stop_out = 1'b1;
        end
    end

    assign link.redundant_peripheral_clock        = red_clk_out;
    assign link.redundant_peripheral_clock_enable = red_en_out;
    assign link.redundant_peripheral_clock_stop   = red_stop_out;
endmodule

// ===== pkg/pcg_regs.svh
// Timing and ratio constants for the peripheral clock enable generator.
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

`define PCG_RATIO_DEFAULT     3
`define PCG_RATIO_MIN         2
`define PCG_RED_DELAY_DEFAULT 2
`define PCG_CNT_W             8

`endif

// ===== pkg/pcg_pkg.sv
// Types shared by both ends of the peripheral clock enable link.
`include "pcg_regs.svh"

package pcg_pkg;
    typedef logic [`PCG_CNT_W-1:0] pcg_cnt_t;
    typedef enum logic [1:0] {
        PCG_IDLE,
        PCG_RUN
    } pcg_state_e;
endpackage

// ===== pkg/pcg_link_if.sv
// Link between the clock source end and the peripheral end.
interface pcg_link_if;
    logic peripheral_clock;
    logic peripheral_clock_enable;
    logic redundant_peripheral_clock;
    logic redundant_peripheral_clock_enable;
    logic redundant_peripheral_clock_stop;

    modport src (
        output peripheral_clock,
        output peripheral_clock_enable,
        output redundant_peripheral_clock,
        output redundant_peripheral_clock_enable,
        output redundant_peripheral_clock_stop
    );
    modport periph (
        input peripheral_clock,
        input peripheral_clock_enable,
        input redundant_peripheral_clock,
        input redundant_peripheral_clock_enable,
        input redundant_peripheral_clock_stop
    );
endinterface

// ===== core/pcg_periph.sv
// Peripheral end: advances a tick counter only on enabled main clock edges.
`include "pcg_regs.svh"

module pcg_periph #(
    parameter int TICK_W = 16
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    pcg_link_if.periph             link,
    output logic [TICK_W-1:0]      o_tick_count,
    output logic [TICK_W-1:0]      o_red_tick_count,
    output logic                   o_active_edge
);
    import pcg_pkg::*;

    // ------------------------------------------------------------
    // Primary and redundant tick counters
    // ------------------------------------------------------------
    // The enable is same-domain logic, so it is read without synchronisers.
    logic [TICK_W-1:0] tick;
    logic [TICK_W-1:0] next_tick;
    logic [TICK_W-1:0] rtick;
    logic [TICK_W-1:0] next_rtick;
    logic              act;
    logic              next_act;

    always_comb begin
        next_tick  = link.peripheral_clock_enable ? tick + TICK_W'(1) : tick;
        next_rtick = rtick;
        if (!link.redundant_peripheral_clock_stop && link.redundant_peripheral_clock_enable) begin
            next_rtick = rtick + TICK_W'(1);
        end
        next_act   = link.peripheral_clock_enable;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick  <= '0;
            rtick <= '0;
            act   <= 1'b0;
        end else begin
            tick  <= next_tick;
            rtick <= next_rtick;
            act   <= next_act;
        end
    end

    assign o_tick_count     = tick;
    assign o_red_tick_count = rtick;
    assign o_active_edge    = act;
endmodule

// ===== tb/pcg_link_chk.sv
// Assertions on the link between the clock source end and the peripheral end.
module pcg_link_chk (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_clock_stop,
    input wire logic peripheral_clock,
    input wire logic peripheral_clock_enable,
    input wire logic redundant_peripheral_clock,
    input wire logic redundant_peripheral_clock_enable,
    input wire logic redundant_peripheral_clock_stop
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic pen = peripheral_clock_enable;
    wire logic pclk = peripheral_clock;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    // The figures assume the bench ratio of three and redundant delay of two.
    chk_en_one_cycle: assert property (pen |=> !pen [*2])
        else $error("enable not spaced");
    chk_en_period: assert property (pen && !i_clock_stop ##1 !i_clock_stop [*2] |=> pen)
        else $error("enable period wrong");
    chk_rise_has_en: assert property ($rose(pclk) |-> pen)
        else $error("clock rise without enable");
    chk_clk_shape: assert property (pen |-> pclk ##1 !pclk)
        else $error("clock shape wrong");
    chk_red_en_delay: assert property (redundant_peripheral_clock_enable == $past(pen, 2))
        else $error("redundant enable delay wrong");
    chk_red_clk_delay: assert property (redundant_peripheral_clock == $past(pclk, 2))
        else $error("redundant clock delay wrong");
    chk_start_clean: assert property (!$past(i_nrst) && !i_clock_stop |-> ##[1:3] pen)
        else $error("no enable after reset");
    chk_stop_idle: assert property (i_clock_stop |=> !pen && !pclk)
        else $error("enable while stopped");
    cov_en: cover property (pen);
    cov_red_en: cover property (redundant_peripheral_clock_enable);
    cov_restart: cover property (i_clock_stop ##1 !i_clock_stop);
endmodule

// ===== tb/tb_peripheral_clock_enable_gen.sv
// Self-checking bench for both ends of the peripheral clock enable link.
module tb_peripheral_clock_enable_gen;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_sys_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_clock_stop = 1'b0;
    logic [15:0] o_tick_count;
    logic [15:0] o_red_tick_count;
    logic        o_active_edge;
    logic        main_clk;
    logic [15:0] t0;
    logic [15:0] r0;
    int          num_errors = 0;
    int          checks = 0;
    int          acts;
    pcg_link_if link ();
    always #5 i_sys_clk = ~i_sys_clk;
    pcg_source pcg_source_i (.i_sys_clk, .i_nrst, .i_clock_stop, .link(link),
        .o_main_clock(main_clk));
    pcg_periph pcg_periph_i (.i_sys_clk, .i_nrst, .link(link), .o_tick_count,
        .o_red_tick_count, .o_active_edge);
    pcg_link_chk pcg_link_chk_i (.i_sys_clk, .i_nrst, .i_clock_stop,
        .peripheral_clock(link.peripheral_clock),
        .peripheral_clock_enable(link.peripheral_clock_enable),
        .redundant_peripheral_clock(link.redundant_peripheral_clock),
        .redundant_peripheral_clock_enable(link.redundant_peripheral_clock_enable),
        .redundant_peripheral_clock_stop(link.redundant_peripheral_clock_stop));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input int n);
        acts = 0;
        repeat (n) begin
            @(posedge i_sys_clk);
            if (o_active_edge === 1'b1) acts++;
        end
    endtask
    // Bounded wait: an idle cycle plus a full count must fit in eight edges.
    task automatic wait_act();
        for (int i = 0; i < 8 && o_active_edge !== 1'b1; i++) @(posedge i_sys_clk);
        chk(o_active_edge, 16'h0001);
    endtask
    // Any thirty-edge window of a running clock holds exactly thirty over the ratio of three enables.
    task automatic window(input logic [15:0] n);
        t0 = o_tick_count;
        r0 = o_red_tick_count;
        run(30);
        chk(o_tick_count - t0, n);
        chk(o_red_tick_count - r0, n);
        chk(16'(acts), n);
    endtask
    task automatic stop_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // The main clock is looked at once high and once low, away from its edges.
    initial begin
        #17;
        chk(16'(main_clk), 16'h0001);
        #5;
        chk(16'(main_clk), 16'h0000);
    end
    initial begin
        #5000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        wait_act();
        window(16'h000a);
        $display("test 1 done");
        i_clock_stop <= 1'b1;
        run(4);
        window(16'h0000);
        i_clock_stop <= 1'b0;
        wait_act();
        window(16'h000a);
        $display("test 2 done");
        stop_test();
    end
endmodule
